// >>> hw/data_space_pkg.sv
// constants for the data-space map, the read-only window and the stack
// assumes an 8-bit data space and a 12-bit program space on one clock
//
// Behaviour
// - 12-bit program counter reaches 4K bytes directly
// - six-entry 12-bit return stack for nesting
// - reads 040h-07Fh come from program memory
// - block N maps to N*64 plus offset
// - reset leaves block select undefined; software writes
// - protection option blocks external program memory reads
// - 080h-083h are index and short direct registers
// - port latches reset 00h; inputs read pins
// - port direction registers at 0C4h/0C5h reset 00h
// - port option registers at 0CCh/0CDh reset 00h
// - 0C8h and 0C9h write-only, undefined after reset
// - converter result read-only; control resets to 40h
// - timer registers reset 7Fh, 0FFh and 00h
// - block number in low six bits
// - protection comes from low option byte bit 7
package data_space_pkg;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 6;
  localparam int BLOCK_W = 6;
  localparam int OFFSET_W = 6;

  // ----------------------------------------------------------------
  // data-space offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RAM_BASE = 8'h00;
  localparam logic [7:0] RAM_LAST = 8'h3F;
  localparam logic [7:0] WINDOW_BASE = 8'h40;
  localparam logic [7:0] WINDOW_LAST = 8'h7F;
  localparam logic [7:0] INDEX_X = 8'h80;
  localparam logic [7:0] INDEX_Y = 8'h81;
  localparam logic [7:0] SHORT_DIRECT_V = 8'h82;
  localparam logic [7:0] SHORT_DIRECT_W = 8'h83;
  localparam logic [7:0] PORT_A_OUTPUT_LATCH = 8'hC0;
  localparam logic [7:0] PORT_B_OUTPUT_LATCH = 8'hC1;
  localparam logic [7:0] PORT_A_DIRECTION = 8'hC4;
  localparam logic [7:0] PORT_B_DIRECTION = 8'hC5;
  localparam logic [7:0] INTERRUPT_OPTION = 8'hC8;
  localparam logic [7:0] ROM_WINDOW_BLOCK_SELECT = 8'hC9;
  localparam logic [7:0] PORT_A_PIN_CONFIG = 8'hCC;
  localparam logic [7:0] PORT_B_PIN_CONFIG = 8'hCD;
  localparam logic [7:0] CONVERTER_RESULT = 8'hD0;
  localparam logic [7:0] CONVERTER_CONTROL = 8'hD1;
  localparam logic [7:0] TIMER_PRESCALER = 8'hD2;
  localparam logic [7:0] TIMER_DOWNCOUNTER = 8'hD3;
  localparam logic [7:0] TIMER_STATUS_CONTROL = 8'hD4;
  localparam logic [7:0] WATCHDOG_COUNTER = 8'hD8;
  localparam logic [7:0] ACCUMULATOR = 8'hFF;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] CONVERTER_CONTROL_RESET = 8'h40;
  localparam logic [7:0] TIMER_PRESCALER_RESET = 8'h7F;
  localparam logic [7:0] TIMER_DOWNCOUNTER_RESET = 8'hFF;
  localparam logic [7:0] TIMER_STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] WATCHDOG_COUNTER_RESET = 8'hFE;
  localparam logic [7:0] UNDEFINED_READ = 8'h00;
  localparam int PROTECT_BIT = 7;
  localparam logic [PC_W-1:0] PC_RESET = 12'hFFE;
endpackage

// >>> hw/return_stack.sv
// six-level hardware return stack of program addresses
// assumes the caller never pushes and pops in the same cycle
`timescale 1ns/1ns
`default_nettype none
module return_stack
  import data_space_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_addr,
  output logic [WIDTH-1:0] top,
  output logic [3:0] level
);
  logic [WIDTH-1:0] entry [DEPTH];

  // ----------------------------------------------------------------
  // shift stack
  // ----------------------------------------------------------------
  // a seventh push drops the oldest entry, as a shift stack does
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk) begin
        if (push) begin
          entry[i] <= (i == 0) ? push_addr : entry[(i == 0) ? 0 : i-1];
        end else if (pop) begin
          entry[i] <= (i == DEPTH-1) ? entry[i] : entry[(i+1) % DEPTH];
        end
      end
    end
  endgenerate

  assign top = entry[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 4'h0;
    end else if (push && level != 4'(DEPTH)) begin
      level <= level + 4'h1;
    end else if (pop && level != 4'h0) begin
      level <= level - 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> hw/data_space_map.sv
// data-space decoder, read-only program window, registers and stack
// assumes a core on the same clock issuing one read or write a cycle
`timescale 1ns/1ns
`default_nettype none
module data_space_map
  import data_space_pkg::*;
#(
  parameter logic [7:0] CONV_RO_MASK = 8'hC0
) (
  input wire logic clk,
  input wire logic rst,
  // core data-space access
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [7:0] data_addr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  output logic data_rvalid,
  // core program flow
  input wire logic pc_step,
  input wire logic pc_jump,
  input wire logic pc_call,
  input wire logic pc_return,
  input wire logic [PC_W-1:0] pc_target,
  output logic [PC_W-1:0] program_counter,
  output logic [3:0] stack_level,
  // program memory data port, combinational read
  output logic [PC_W-1:0] rom_addr,
  input wire logic [7:0] rom_rdata,
  // external readout path
  input wire logic ext_rd_req,
  input wire logic [PC_W-1:0] ext_rd_addr,
  output logic [7:0] ext_rd_data,
  output logic ext_rd_valid,
  output logic ext_rd_denied,
  input wire logic [7:0] option_low,
  // pins and peripheral files
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  output logic [7:0] port_a_output_latch,
  output logic [7:0] port_b_output_latch,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_a_pin_config,
  output logic [7:0] port_b_pin_config,
  output logic [7:0] interrupt_option,
  input wire logic [7:0] converter_result,
  input wire logic [7:0] converter_status,
  output logic [7:0] converter_control,
  output logic [7:0] timer_prescaler,
  output logic [7:0] timer_downcounter,
  output logic [7:0] timer_status_control,
  output logic [7:0] watchdog_counter
);
  logic [7:0] ram [64];
  logic [7:0] index_x, index_y, short_direct_v, short_direct_w;
  logic [7:0] accumulator;
  logic [7:0] rom_window_block_select;
  logic [7:0] pa_meta, pa_sync, pb_meta, pb_sync, opt_meta, opt_sync;
  logic protect;
  logic rd_pend, rd_win;
  logic [7:0] rd_addr;
  logic ext_pend;
  logic [PC_W-1:0] stack_top;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire in_ram = data_addr <= RAM_LAST;
  wire in_window = data_addr >= WINDOW_BASE && data_addr <= WINDOW_LAST;
  wire wr_ram = data_wr && in_ram;
  wire wr_x = data_wr && data_addr == INDEX_X;
  wire wr_y = data_wr && data_addr == INDEX_Y;
  wire wr_v = data_wr && data_addr == SHORT_DIRECT_V;
  wire wr_w = data_wr && data_addr == SHORT_DIRECT_W;
  wire wr_acc = data_wr && data_addr == ACCUMULATOR;
  wire wr_pa = data_wr && data_addr == PORT_A_OUTPUT_LATCH;
  wire wr_pb = data_wr && data_addr == PORT_B_OUTPUT_LATCH;
  wire wr_da = data_wr && data_addr == PORT_A_DIRECTION;
  wire wr_db = data_wr && data_addr == PORT_B_DIRECTION;
  wire wr_ca = data_wr && data_addr == PORT_A_PIN_CONFIG;
  wire wr_cb = data_wr && data_addr == PORT_B_PIN_CONFIG;
  wire wr_int_opt = data_wr && data_addr == INTERRUPT_OPTION;
  wire wr_blk = data_wr && data_addr == ROM_WINDOW_BLOCK_SELECT;
  wire wr_cc = data_wr && data_addr == CONVERTER_CONTROL;
  wire wr_tp = data_wr && data_addr == TIMER_PRESCALER;
  wire wr_td = data_wr && data_addr == TIMER_DOWNCOUNTER;
  wire wr_ts = data_wr && data_addr == TIMER_STATUS_CONTROL;
  wire wr_wd = data_wr && data_addr == WATCHDOG_COUNTER;
  wire win_rd = data_rd && in_window;
  wire [PC_W-1:0] window_addr =
    {rom_window_block_select[BLOCK_W-1:0], data_addr[OFFSET_W-1:0]};
  wire ext_issue = ext_rd_req && !ext_pend && !ext_rd_valid && !win_rd;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    pa_meta <= port_a_pins;
    pa_sync <= pa_meta;
    pb_meta <= port_b_pins;
    pb_sync <= pb_meta;
    opt_meta <= option_low;
    opt_sync <= opt_meta;
  end

  // protected until the option level has crossed the synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      protect <= 1'b1;
    end else begin
      protect <= opt_sync[PROTECT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // registers without reset value
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (wr_ram) begin
      ram[data_addr[5:0]] <= data_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_x) index_x <= data_wdata;
    if (wr_y) index_y <= data_wdata;
    if (wr_v) short_direct_v <= data_wdata;
    if (wr_w) short_direct_w <= data_wdata;
    if (wr_acc) accumulator <= data_wdata;
    if (wr_int_opt) interrupt_option <= data_wdata;
  end

  // reset does not touch the block select; software loads it first
  always_ff @(posedge clk) begin
    if (wr_blk) begin
      rom_window_block_select <=
        {2'b00, data_wdata[BLOCK_W-1:0]};
    end
  end

  // ----------------------------------------------------------------
  // registers with reset value
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_output_latch <= PORT_RESET;
      port_b_output_latch <= PORT_RESET;
      port_a_direction <= PORT_RESET;
      port_b_direction <= PORT_RESET;
      port_a_pin_config <= PORT_RESET;
      port_b_pin_config <= PORT_RESET;
    end else begin
      if (wr_pa) port_a_output_latch <= data_wdata;
      if (wr_pb) port_b_output_latch <= data_wdata;
      if (wr_da) port_a_direction <= data_wdata;
      if (wr_db) port_b_direction <= data_wdata;
      if (wr_ca) port_a_pin_config <= data_wdata;
      if (wr_cb) port_b_pin_config <= data_wdata;
    end
  end

  // read-only control bits keep their value; only writable bits load
  always_ff @(posedge clk) begin
    if (rst) begin
      converter_control <= CONVERTER_CONTROL_RESET;
      timer_prescaler <= TIMER_PRESCALER_RESET;
      timer_downcounter <= TIMER_DOWNCOUNTER_RESET;
      timer_status_control <= TIMER_STATUS_CONTROL_RESET;
      watchdog_counter <= WATCHDOG_COUNTER_RESET;
    end else begin
      if (wr_cc) begin
        converter_control <= (converter_control & CONV_RO_MASK) |
          (data_wdata & ~CONV_RO_MASK);
      end
      if (wr_tp) timer_prescaler <= data_wdata;
      if (wr_td) timer_downcounter <= data_wdata;
      if (wr_ts) timer_status_control <= data_wdata;
      if (wr_wd) watchdog_counter <= data_wdata;
    end
  end

  // ----------------------------------------------------------------
  // read path: request, program memory cycle, answer
  // ----------------------------------------------------------------
  // every read answers two edges later so window and register reads
  // look alike to the core; the cost is one cycle on register reads
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_pend <= 1'b0;
      rd_win <= 1'b0;
      rd_addr <= 8'h00;
      rom_addr <= '0;
      ext_pend <= 1'b0;
    end else begin
      rd_pend <= data_rd;
      rd_win <= win_rd;
      rd_addr <= data_addr;
      ext_pend <= ext_issue;
      if (win_rd) begin
        rom_addr <= window_addr;
      end else if (ext_issue && !protect) begin
        rom_addr <= ext_rd_addr;
      end
    end
  end

  // input pins read through the two-stage synchroniser, output pins read the latch
  wire [7:0] pa_read = (port_a_output_latch & port_a_direction) |
    (pa_sync & ~port_a_direction);
  wire [7:0] pb_read = (port_b_output_latch & port_b_direction) |
    (pb_sync & ~port_b_direction);
  wire [7:0] cc_read = (converter_status & CONV_RO_MASK) |
    (converter_control & ~CONV_RO_MASK);

  logic [7:0] read_mux;
  always_comb begin
    read_mux = UNDEFINED_READ;
    if (rd_win) begin
      read_mux = rom_rdata;
    end else if (rd_addr <= RAM_LAST) begin
      read_mux = ram[rd_addr[5:0]];
    end else begin
      unique case (rd_addr)
        INDEX_X: read_mux = index_x;
        INDEX_Y: read_mux = index_y;
        SHORT_DIRECT_V: read_mux = short_direct_v;
        SHORT_DIRECT_W: read_mux = short_direct_w;
        PORT_A_OUTPUT_LATCH: read_mux = pa_read;
        PORT_B_OUTPUT_LATCH: read_mux = pb_read;
        PORT_A_DIRECTION: read_mux = port_a_direction;
        PORT_B_DIRECTION: read_mux = port_b_direction;
        PORT_A_PIN_CONFIG: read_mux = port_a_pin_config;
        PORT_B_PIN_CONFIG: read_mux = port_b_pin_config;
        CONVERTER_RESULT: read_mux = converter_result;
        CONVERTER_CONTROL: read_mux = cc_read;
        TIMER_PRESCALER: read_mux = timer_prescaler;
        TIMER_DOWNCOUNTER: read_mux = timer_downcounter;
        TIMER_STATUS_CONTROL: read_mux = timer_status_control;
        WATCHDOG_COUNTER: read_mux = watchdog_counter;
        ACCUMULATOR: read_mux = accumulator;
        default: read_mux = UNDEFINED_READ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_rdata <= 8'h00;
      data_rvalid <= 1'b0;
      ext_rd_data <= 8'h00;
      ext_rd_valid <= 1'b0;
      ext_rd_denied <= 1'b0;
    end else begin
      data_rvalid <= rd_pend;
      if (rd_pend) data_rdata <= read_mux;
      ext_rd_valid <= ext_pend;
      ext_rd_denied <= ext_pend && protect;
      if (ext_pend) ext_rd_data <= protect ? 8'h00 : rom_rdata;
    end
  end

  // ----------------------------------------------------------------
  // program counter and return stack
  // ----------------------------------------------------------------
  wire [PC_W-1:0] pc_next_seq = program_counter + PC_W'(1);

  always_ff @(posedge clk) begin
    if (rst) begin
      program_counter <= PC_RESET;
    end else if (pc_return) begin
      program_counter <= stack_top;
    end else if (pc_call || pc_jump) begin
      program_counter <= pc_target;
    end else if (pc_step) begin
      program_counter <= pc_next_seq;
    end
  end

  return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .clk(clk),
    .rst(rst),
    .push(pc_call && !pc_return),
    .pop(pc_return),
    .push_addr(pc_next_seq),
    .top(stack_top),
    .level(stack_level)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_WINDOW_ADDR: assert property (
    win_rd |=> rom_addr == {$past(rom_window_block_select[5:0]),
      $past(data_addr[5:0])})
    else $error("window address not block and offset");
  AST_WINDOW_DATA: assert property (
    win_rd ##1 1'b1 |=> data_rvalid && data_rdata == $past(rom_rdata))
    else $error("window read not from program memory");
  AST_BLOCK_NEXT: assert property (
    wr_blk ##1 win_rd |=> rom_addr[11:6] == $past(data_wdata[5:0], 2))
    else $error("block select write missed next window read");
  AST_BLOCK_UPPER: assert property (
    $past(wr_blk) |-> rom_window_block_select[7:6] == 2'b00)
    else $error("block select upper bits not zero");
  AST_PROTECT: assert property (
    protect && ext_pend |=> ext_rd_denied && ext_rd_data == 8'h00)
    else $error("protected readout leaked data");
  AST_PROTECT_ADDR: assert property (
    protect && ext_issue && !win_rd |=> $stable(rom_addr))
    else $error("protected readout reached program memory");
  AST_PORT_READ: assert property (
    rd_pend && rd_addr == PORT_A_OUTPUT_LATCH && !rd_win
      |=> data_rdata == $past(pa_read))
    else $error("port read mixes latch and pins wrongly");
  AST_RESET_VALUES: assert property (
    $rose(!rst) |-> timer_prescaler == 8'h7F &&
      timer_downcounter == 8'hFF && converter_control == 8'h40)
    else $error("timer or converter reset value wrong");
  AST_PORT_RESET: assert property (
    $fell(rst) |-> port_a_direction == 8'h00 && port_b_pin_config == 8'h00)
    else $error("port control reset value wrong");
  AST_RO_WRITE: assert property (
    data_wr && data_addr == CONVERTER_RESULT
      |=> $stable(timer_prescaler) && $stable(converter_control))
    else $error("read-only write disturbed a register");
  AST_CALL_RET: assert property (
    pc_call && !pc_return ##1 pc_return && !pc_call
      |=> program_counter == $past(program_counter, 2) + 12'h001)
    else $error("return did not restore caller address");
  AST_PC_STEP: assert property (
    pc_step && !pc_jump && !pc_call && !pc_return
      |=> program_counter == $past(program_counter) + 12'h001)
    else $error("program counter did not advance");
  AST_INDEX_RW: assert property (
    wr_x ##1 !wr_x |-> index_x == $past(data_wdata))
    else $error("index register lost write");
  AST_IOR_WO: assert property (
    rd_pend && !rd_win && rd_addr == INTERRUPT_OPTION
      |=> data_rdata == 8'h00)
    else $error("write-only register read back");
endmodule
`default_nettype wire

// >>> test/prog_mem_model.sv
// program memory model feeding the map's combinational data port
// assumes the map registers rom_addr and samples rom_rdata on clk
`timescale 1ns/1ns
`default_nettype none
module prog_mem_model
  import data_space_pkg::*;
(
  input wire logic [PC_W-1:0] rom_addr,
  output logic [7:0] rom_rdata
);
  // pattern mixes block and offset, so a wrong block or offset shows up
  assign rom_rdata = rom_addr[7:0] ^ {2'b00, rom_addr[11:6]};
endmodule
`default_nettype wire

// >>> test/tb_data_space_map_rom_window.sv
// self-checking bench for the data-space map and its read-only window
// assumes the design package, the map and prog_mem_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_data_space_map_rom_window;
  import data_space_pkg::*;
  localparam logic [7:0] RO_MASK = 8'hC0;
  logic clk, rst, data_rd, data_wr, data_rvalid;
  logic [7:0] data_addr, data_wdata, data_rdata, rom_rdata, option_low;
  logic pc_step, pc_jump, pc_call, pc_return;
  logic [PC_W-1:0] pc_target, program_counter, rom_addr, ext_rd_addr;
  logic [3:0] stack_level;
  logic ext_rd_req, ext_rd_valid, ext_rd_denied;
  logic [7:0] ext_rd_data, port_a_pins, port_b_pins, converter_result;
  logic [7:0] converter_status, port_a_output_latch, port_b_output_latch;
  logic [7:0] port_a_direction, port_b_direction, port_a_pin_config;
  logic [7:0] port_b_pin_config, interrupt_option, converter_control;
  logic [7:0] timer_prescaler, timer_downcounter, timer_status_control;
  logic [7:0] watchdog_counter;
  int n_errors = 0;
  int n_compared = 0;

  data_space_map #(.CONV_RO_MASK(RO_MASK)) i_dut (
    .clk, .rst, .data_rd, .data_wr, .data_addr, .data_wdata, .data_rdata,
    .data_rvalid, .pc_step, .pc_jump, .pc_call, .pc_return, .pc_target,
    .program_counter, .stack_level, .rom_addr, .rom_rdata, .ext_rd_req,
    .ext_rd_addr, .ext_rd_data, .ext_rd_valid, .ext_rd_denied, .option_low,
    .port_a_pins, .port_b_pins, .port_a_output_latch, .port_b_output_latch,
    .port_a_direction, .port_b_direction, .port_a_pin_config,
    .port_b_pin_config, .interrupt_option, .converter_result,
    .converter_status, .converter_control, .timer_prescaler,
    .timer_downcounter, .timer_status_control, .watchdog_counter
  );
  prog_mem_model i_prog_mem (.rom_addr, .rom_rdata);

  always #5 clk = ~clk;

  // ------------------------------------------------------------------
  // shared helpers; every task is entered and left at a falling edge
  // ------------------------------------------------------------------
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] rom_byte(input logic [11:0] a);
    return a[7:0] ^ {2'b00, a[11:6]};
  endfunction

  // write strobe stays up so writes can go back to back; rd drops it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    data_wr = 1'b1;
    data_addr = a;
    data_wdata = d;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int k;
    data_wr = 1'b0;
    data_rd = 1'b1;
    data_addr = a;
    @(negedge clk);
    data_rd = 1'b0;
    k = 1;
    while (data_rvalid !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    check(16'(k), 16'h0002);
    check({8'h00, data_rdata}, {8'h00, exp});
    if (k >= 8) give_verdict();
  endtask

  // op bits are return, call, jump, step; the caller clears them after
  task automatic pc_op(input logic [3:0] op, input logic [11:0] t,
      input logic [11:0] exp_pc, input logic [3:0] exp_lvl);
    {pc_return, pc_call, pc_jump, pc_step} = op;
    pc_target = t;
    @(negedge clk);
    check({program_counter, stack_level}, {exp_pc, exp_lvl});
  endtask

  task automatic ext_read(input logic [11:0] a, input logic [7:0] exp_d,
      input logic exp_den);
    int k;
    ext_rd_req = 1'b1;
    ext_rd_addr = a;
    k = 0;
    while (ext_rd_valid !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    ext_rd_req = 1'b0;
    check(16'(k), 16'h0002);
    check({7'h00, ext_rd_denied, ext_rd_data}, {7'h00, exp_den, exp_d});
    if (k >= 8) give_verdict();
    @(negedge clk);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_reset_values;
    check({port_a_output_latch, port_b_output_latch}, 16'h0000);
    check({port_a_direction, port_b_direction}, 16'h0000);
    check({port_a_pin_config, port_b_pin_config}, 16'h0000);
    check({timer_prescaler, timer_downcounter}, 16'h7FFF);
    check({timer_status_control, converter_control}, 16'h0040);
    check({watchdog_counter, 4'h0, stack_level}, 16'hFE00);
    check({4'h0, program_counter}, {4'h0, PC_RESET});
    rd(PORT_A_OUTPUT_LATCH, port_a_pins);
    rd(CONVERTER_CONTROL, 8'h40);
    rd(TIMER_PRESCALER, 8'h7F);
    rd(CONVERTER_RESULT, converter_result);
    $display("done: reset values");
  endtask

  task automatic test_rw_regs;
    logic [7:0] regs [15] = '{INDEX_X, INDEX_Y, SHORT_DIRECT_V,
      SHORT_DIRECT_W, PORT_A_DIRECTION, PORT_B_DIRECTION, PORT_A_PIN_CONFIG,
      PORT_B_PIN_CONFIG, TIMER_PRESCALER, TIMER_DOWNCOUNTER,
      TIMER_STATUS_CONTROL, WATCHDOG_COUNTER, ACCUMULATOR, RAM_BASE,
      RAM_LAST};
    logic [7:0] vals [15];
    for (int i = 0; i < 15; i++) begin
      vals[i] = 8'hA5 ^ 8'(i * 17);
      // port A direction and pin config values keep only the low four bits, so their upper bits stay at the 00h reset value
      if (i == 4 || i == 6) vals[i] = vals[i] & 8'h0F;
      wr(regs[i], vals[i]);
    end
    for (int i = 0; i < 15; i++) begin
      rd(regs[i], vals[i]);
    end
    check({port_b_direction, port_b_pin_config}, {vals[5], vals[7]});
    $display("done: read/write registers");
  endtask

  task automatic test_window;
    logic [5:0] off;
    for (int b = 0; b < 64; b++) begin
      off = 6'(b * 7);
      wr(ROM_WINDOW_BLOCK_SELECT, {2'b00, 6'(b)});
      rd(WINDOW_BASE + {2'b00, off}, rom_byte({6'(b), off}));
    end
    rd(WINDOW_LAST, rom_byte(12'hFFF));
    wr(ROM_WINDOW_BLOCK_SELECT, 8'h01);
    rd(WINDOW_BASE, rom_byte(12'h040));
    $display("done: window");
  endtask

  task automatic test_ports;
    wr(PORT_A_DIRECTION, 8'h0F);
    wr(PORT_A_OUTPUT_LATCH, 8'h0A);
    wr(PORT_B_DIRECTION, 8'hF0);
    wr(PORT_B_OUTPUT_LATCH, 8'h3C);
    rd(PORT_A_OUTPUT_LATCH, 8'h0A | (port_a_pins & 8'hF0));
    rd(PORT_B_OUTPUT_LATCH, 8'h30 | (port_b_pins & 8'h0F));
    check({port_a_output_latch, port_b_output_latch}, 16'h0A3C);
    $display("done: ports");
  endtask

  task automatic test_refused;
    wr(INTERRUPT_OPTION, 8'h5C);
    wr(8'hC6, 8'h77);
    check({8'h00, interrupt_option}, 16'h005C);
    rd(INTERRUPT_OPTION, UNDEFINED_READ);
    rd(8'hC6, UNDEFINED_READ);
    rd(8'hD5, UNDEFINED_READ);
    wr(CONVERTER_RESULT, 8'hEE);
    rd(CONVERTER_RESULT, converter_result);
    // read-only bits must follow the status input, not the stored reset value
    converter_status = 8'h80;
    wr(CONVERTER_CONTROL, 8'h3F);
    rd(CONVERTER_CONTROL, (converter_status & RO_MASK) | 8'h3F);
    wr(ROM_WINDOW_BLOCK_SELECT, 8'h05);
    wr(8'h45, 8'h11);
    rd(8'h45, rom_byte(12'h145));
    $display("done: refused accesses");
  endtask

  task automatic test_flow;
    logic [11:0] ret [7];
    logic [11:0] cur;
    pc_op(4'h2, 12'hFFF, 12'hFFF, 4'h0);
    pc_op(4'h1, 12'h000, 12'h000, 4'h0);
    cur = 12'h000;
    for (int i = 0; i < 7; i++) begin
      ret[i] = cur + 12'h001;
      cur = 12'h100 + 12'(i * 16);
      pc_op(4'h4, cur, cur, (i < 6) ? 4'(i + 1) : 4'h6);
    end
    for (int i = 6; i > 0; i--) begin
      pc_op(4'h8, 12'h000, ret[i], 4'(i - 1));
    end
    {pc_return, pc_call, pc_jump, pc_step} = 4'h0;
    @(negedge clk);
    $display("done: program flow");
  endtask

  task automatic test_protect;
    ext_read(12'h123, 8'h00, 1'b1);
    option_low = 8'h7F;
    repeat (4) @(negedge clk);
    ext_read(12'h123, rom_byte(12'h123), 1'b0);
    ext_read(12'hFC0, rom_byte(12'hFC0), 1'b0);
    option_low = 8'h80;
    repeat (4) @(negedge clk);
    ext_read(12'hFC0, 8'h00, 1'b1);
    $display("done: readout protection");
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {data_rd, data_wr, pc_step, pc_jump, pc_call, pc_return} = 6'h00;
    ext_rd_req = 1'b0;
    {data_addr, data_wdata} = 16'h0000;
    {pc_target, ext_rd_addr} = 24'h000000;
    option_low = 8'h80;
    port_a_pins = 8'h5A;
    port_b_pins = 8'hA5;
    converter_result = 8'h3C;
    converter_status = 8'h40;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    test_reset_values();
    test_rw_regs();
    test_window();
    test_ports();
    test_refused();
    test_flow();
    test_protect();
    give_verdict();
  end
endmodule
`default_nettype wire
